// [rtl/ums_map.svh]
// Register offsets, field positions and reset values of the modem status and interrupt block
`ifndef UMS_MAP_SVH
`define UMS_MAP_SVH
`define UMS_OFF_MODEM_STATUS 12'h000
`define UMS_OFF_INT_MASK 12'h004
`define UMS_OFF_INT_SOURCE 12'h008
`define UMS_OFF_MODEM_CTRL 12'h00C
`define UMS_OFF_ENH_CTRL 12'h010
`define UMS_OFF_FIFO_CTRL 12'h014
`define UMS_OFF_EVENTS 12'h018
`define UMS_INT_MASK_RST 8'h00
`define UMS_MODEM_CTRL_RST 8'h00
`define UMS_ENH_CTRL_RST 8'h00
`define UMS_FIFO_CTRL_RST 8'h00
`define UMS_MC_LOOP 4
`define UMS_EF_ENH 4
`define UMS_FC_FIFO_EN 0
`define UMS_IM_RHR 0
`define UMS_IM_THR 1
`define UMS_IM_LSR 2
`define UMS_IM_MODEM 3
`define UMS_IM_SLEEP 4
`define UMS_IM_XOFF 5
`define UMS_IM_RTS 6
`define UMS_IM_CTS 7
`define UMS_ID_LINE 6'h06
`define UMS_ID_TMO 6'h0C
`define UMS_ID_RHR 6'h04
`define UMS_ID_THR 6'h02
`define UMS_ID_MODEM 6'h00
`define UMS_ID_XOFF 6'h10
`define UMS_ID_FLOW 6'h20
`define UMS_ID_NONE 6'h01
`endif

// [rtl/ums_pkg.sv]
// Types shared by the modem status and interrupt block
package ums_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ums_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ums_apb_rsp_t;

   // Active-low modem input pins
   typedef struct packed {
      logic cd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } ums_modem_pins_t;

   // Interrupt sources raised by the receiver, transmitter and flow logic
   typedef struct packed {
      logic line_err;
      logic rx_timeout;
      logic rx_ready;
      logic tx_below;
      logic xoff_det;
      logic flow_rise;
   } ums_sources_t;

   typedef struct packed {
      ums_apb_rsp_t apb;
      logic [2:0][3:0] sync;
      logic [3:0] prev;
      logic prev_valid;
      logic [3:0] delta;
      logic [7:0] int_mask;
      logic [7:0] modem_ctrl;
      logic [7:0] enh_ctrl;
      logic [7:0] fifo_ctrl;
      logic thr_fresh;
      logic xoff_seen;
      logic flow_seen;
      logic irq;
      logic sleep_en;
      logic loopback;
   } ums_state_t;
endpackage

// [rtl/ums_modem_int.sv]
// Modem status, interrupt mask and interrupt source identification for one channel
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ums_map.svh"

// Contract
// - Status bit 7 is inverted CD pin, or control bit 3 in loopback.
// - Status bit 6 is inverted RI pin, or control bit 2 in loopback.
// - Status bit 5 is inverted DSR pin, or control bit 0 in loopback.
// - Status bit 4 is inverted CTS pin, or control bit 1 in loopback.
// - Status bit 3 sets on any CD change; cleared by status read.
// - Status bit 2 sets on RI low-to-high only; cleared by status read.
// - Status bit 1 sets on any DSR change; cleared by status read.
// - Status bit 0 sets on any CTS change; cleared by status read.
// - Modem pins are active low; their status copies are active high.
// - Mask bits 0-3 enable receive, transmit, line status, modem; reset 0.
// - Mask bits 5,6,7 enable Xoff, RTS, CTS interrupts; reset 0.
// - Mask bit 4 enables sleep mode; reset 0.
// - Mask bits 7-4 writable only while enhanced-control bit 4 is set.
// - Re-enabling transmit mask bit while below threshold raises fresh interrupt.
// - Interrupt output active whenever an enabled interrupt is pending.
// - Source identification is 8-bit read-only, fixed priority.
// - Identification bits 7 and 6 both mirror FIFO-enable bit.
// - Identification bit 0 is 0 when pending, 1 when idle.
// - Bit 4 flags Xoff/special character; bit 5 flags RTS/CTS rise.
// - Priority: line, timeout/receive, transmit, modem, Xoff, flow change.
// - Bits 5-0 carry the fixed code of the highest source.
// - Only the single highest pending source is shown.
// - Control bit 4 selects loopback; control 3-0 feed status 7-4.
module ums_modem_int (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // APB slave
   input wire ums_pkg::ums_apb_req_t apb_req,
   output var ums_pkg::ums_apb_rsp_t apb_rsp,
   // Modem pins, active low
   input wire ums_pkg::ums_modem_pins_t modem_pins,
   // Sources from the rest of the channel
   input wire ums_pkg::ums_sources_t sources,
   // Outputs to the channel
   output logic irq,
   output logic sleep_en,
   output logic loopback,
   output logic [7:0] modem_ctrl
);
   import ums_pkg::*;

   ums_state_t s_q;
   ums_state_t s_d;
   logic [3:0] levels;
   logic [7:0] status_val;
   logic [7:0] id_val;
   logic [5:0] code;
   logic any_pend;
   logic modem_pend;
   logic line_pend;
   logic tmo_pend;
   logic rhr_pend;
   logic thr_pend;
   logic xoff_pend;
   logic flow_pend;
   logic access;
   logic wr;
   logic rd;
   logic [3:0] stable;
   logic [3:0] chg;

   // Active-high levels in order CD, RI, DSR, CTS; pin levels use the settled sample
   always_comb begin
      stable = s_q.sync[2];
      if (s_q.modem_ctrl[`UMS_MC_LOOP]) begin
         levels = {s_q.modem_ctrl[3], s_q.modem_ctrl[2], s_q.modem_ctrl[0], s_q.modem_ctrl[1]};
      end else begin
         levels = ~stable;
      end
   end

   // Change detection against the previous cycle's level
   always_comb begin
      chg = 4'h0;
      if (s_q.prev_valid) begin
         chg[3] = levels[3] ^ s_q.prev[3];
         // Ring flag: the pin going low to high (level falling), or control bit 2 rising in loopback
         chg[2] = s_q.modem_ctrl[`UMS_MC_LOOP] ? (levels[2] & ~s_q.prev[2]) : (~levels[2] & s_q.prev[2]);
         chg[1] = levels[1] ^ s_q.prev[1];
         chg[0] = levels[0] ^ s_q.prev[0];
      end
   end

   assign status_val = {levels, s_q.delta};

   // Pending terms after masking
   assign line_pend = sources.line_err & s_q.int_mask[`UMS_IM_LSR];
   assign tmo_pend = sources.rx_timeout & s_q.int_mask[`UMS_IM_RHR];
   assign rhr_pend = sources.rx_ready & s_q.int_mask[`UMS_IM_RHR];
   assign thr_pend = s_q.thr_fresh & s_q.int_mask[`UMS_IM_THR];
   assign modem_pend = (|s_q.delta) & s_q.int_mask[`UMS_IM_MODEM];
   assign xoff_pend = s_q.xoff_seen & s_q.int_mask[`UMS_IM_XOFF];
   assign flow_pend = s_q.flow_seen & (s_q.int_mask[`UMS_IM_RTS] | s_q.int_mask[`UMS_IM_CTS]);
   assign any_pend = line_pend | tmo_pend | rhr_pend | thr_pend | modem_pend | xoff_pend | flow_pend;

   // Fixed priority encoder, only the top source is reported
   always_comb begin
      if (line_pend) begin
         code = `UMS_ID_LINE;
      end else if (tmo_pend) begin
         code = `UMS_ID_TMO;
      end else if (rhr_pend) begin
         code = `UMS_ID_RHR;
      end else if (thr_pend) begin
         code = `UMS_ID_THR;
      end else if (modem_pend) begin
         code = `UMS_ID_MODEM;
      end else if (xoff_pend) begin
         code = `UMS_ID_XOFF;
      end else if (flow_pend) begin
         code = `UMS_ID_FLOW;
      end else begin
         code = `UMS_ID_NONE;
      end
   end

   // Bits 7:6 mirror FIFO enable
   assign id_val = {{2{s_q.fifo_ctrl[`UMS_FC_FIFO_EN]}}, code};

   // APB access is taken in the access phase; pready follows one cycle later, one wait state
   assign access = apb_req.psel & apb_req.penable & ~s_q.apb.pready;
   assign wr = access & apb_req.pwrite;
   assign rd = access & ~apb_req.pwrite;

   // Next-state logic
   always_comb begin
      s_d = s_q;
      s_d.sync = {s_q.sync[1:0], modem_pins};
      s_d.prev = levels;
      s_d.prev_valid = 1'b1;
      s_d.apb.pready = access;
      s_d.apb.pslverr = 1'b0;
      s_d.apb.prdata = 32'h0000_0000;
      // Flag clear on status read first, so a same-cycle change still sets
      if (rd && apb_req.paddr == `UMS_OFF_MODEM_STATUS) begin
         s_d.delta = 4'h0;
      end
      s_d.delta = s_d.delta | chg;
      // Reading the source id retires the one-shot transmit, Xoff or flow notice it reports
      if (rd && apb_req.paddr == `UMS_OFF_INT_SOURCE && code == `UMS_ID_THR) begin
         s_d.thr_fresh = 1'b0;
      end
      if (rd && apb_req.paddr == `UMS_OFF_INT_SOURCE && code == `UMS_ID_XOFF) begin
         s_d.xoff_seen = 1'b0;
      end
      if (rd && apb_req.paddr == `UMS_OFF_INT_SOURCE && code == `UMS_ID_FLOW) begin
         s_d.flow_seen = 1'b0;
      end
      if (sources.xoff_det) begin
         s_d.xoff_seen = 1'b1;
      end
      if (sources.flow_rise) begin
         s_d.flow_seen = 1'b1;
      end
      // Transmit notice clears when the level drops, and arms only on a mask re-enable
      if (!sources.tx_below) begin
         s_d.thr_fresh = 1'b0;
      end
      if (wr) begin
         unique case (apb_req.paddr)
            `UMS_OFF_INT_MASK: begin
               s_d.int_mask[3:0] = apb_req.pwdata[3:0];
               if (s_q.enh_ctrl[`UMS_EF_ENH]) begin
                  s_d.int_mask[7:4] = apb_req.pwdata[7:4];
               end
               if (apb_req.pwdata[`UMS_IM_THR] && !s_q.int_mask[`UMS_IM_THR] && sources.tx_below) begin
                  s_d.thr_fresh = 1'b1;
               end
            end
            `UMS_OFF_MODEM_CTRL: begin
               s_d.modem_ctrl[4:0] = apb_req.pwdata[4:0];
               if (s_q.enh_ctrl[`UMS_EF_ENH]) begin
                  s_d.modem_ctrl[7:5] = apb_req.pwdata[7:5];
               end
            end
            `UMS_OFF_ENH_CTRL: s_d.enh_ctrl = apb_req.pwdata[7:0];
            `UMS_OFF_FIFO_CTRL: s_d.fifo_ctrl = apb_req.pwdata[7:0];
            default: s_d.apb.pslverr = (apb_req.paddr != `UMS_OFF_MODEM_STATUS)
                                       && (apb_req.paddr != `UMS_OFF_INT_SOURCE)
                                       && (apb_req.paddr != `UMS_OFF_EVENTS);
         endcase
      end
      if (rd) begin
         unique case (apb_req.paddr)
            `UMS_OFF_MODEM_STATUS: s_d.apb.prdata = {24'h00_0000, status_val};
            `UMS_OFF_INT_MASK: s_d.apb.prdata = {24'h00_0000, s_q.int_mask};
            `UMS_OFF_INT_SOURCE: s_d.apb.prdata = {24'h00_0000, id_val};
            `UMS_OFF_MODEM_CTRL: s_d.apb.prdata = {24'h00_0000, s_q.modem_ctrl};
            `UMS_OFF_ENH_CTRL: s_d.apb.prdata = {24'h00_0000, s_q.enh_ctrl};
            `UMS_OFF_FIFO_CTRL: s_d.apb.prdata = {24'h00_0000, s_q.fifo_ctrl};
            `UMS_OFF_EVENTS: s_d.apb.prdata = {30'h0000_0000, s_q.flow_seen, s_q.xoff_seen};
            default: s_d.apb.pslverr = 1'b1;
         endcase
      end
      s_d.irq = any_pend;
      s_d.sleep_en = s_d.int_mask[`UMS_IM_SLEEP];
      s_d.loopback = s_d.modem_ctrl[`UMS_MC_LOOP];
   end

   // State register; synchronous reset to constants only
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.sync <= {3{4'hF}};
         s_q.int_mask <= `UMS_INT_MASK_RST;
         s_q.modem_ctrl <= `UMS_MODEM_CTRL_RST;
         s_q.enh_ctrl <= `UMS_ENH_CTRL_RST;
         s_q.fifo_ctrl <= `UMS_FIFO_CTRL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   assign apb_rsp = s_q.apb;
   assign irq = s_q.irq;
   assign sleep_en = s_q.sleep_en;
   assign loopback = s_q.loopback;
   assign modem_ctrl = s_q.modem_ctrl;
endmodule
`default_nettype wire

// [verification/ums_modem_int_chk.sv]
// Port checker for the modem status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module ums_modem_int_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Bus, pins and sources
   input wire ums_pkg::ums_apb_req_t apb_req,
   input wire ums_pkg::ums_apb_rsp_t apb_rsp,
   input wire ums_pkg::ums_modem_pins_t modem_pins,
   input wire ums_pkg::ums_sources_t sources,
   // Channel outputs
   input wire logic irq,
   input wire logic sleep_en,
   input wire logic loopback,
   input wire logic [7:0] modem_ctrl
);
   import ums_pkg::*;
   logic [3:0] cnt_q;
   logic rd, w4, wc;
   logic [11:0] a;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Quiet time of pins and control; levels lag the synchroniser, so only settled reads are judged
   always_ff @(posedge ref_clk) begin
      if (!resetn || $changed(modem_pins) || $changed(modem_ctrl)) cnt_q <= 4'h0;
      else if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
   end
   // Decoded bus views
   assign a = apb_req.paddr;
   assign rd = apb_rsp.pready && !apb_req.pwrite;
   assign w4 = apb_req.psel && apb_req.pwrite && a == 12'h004;
   assign wc = apb_req.psel && apb_req.pwrite && a == 12'h00C;
   sequence s_take;
      apb_req.psel && apb_req.penable && !apb_rsp.pready;
   endsequence
   chk_ready_wait: assert property (s_take |=> apb_rsp.pready)
      else $error("pready not one cycle after request");
   chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready held too long");
   chk_slverr_map: assert property (apb_rsp.pready && a[1:0] == 2'h0 |-> apb_rsp.pslverr == (a > 12'h018))
      else $error("pslverr wrong for address");
   chk_status_pins: assert property (
      rd && a == 12'h000 && !loopback && cnt_q > 4'h5 |-> apb_rsp.prdata[7:4] == ~modem_pins)
      else $error("status levels differ from pins");
   chk_status_loop: assert property (
      rd && a == 12'h000 && loopback && cnt_q > 4'h5
      |-> apb_rsp.prdata[7:4] == {modem_ctrl[3:2], modem_ctrl[0], modem_ctrl[1]})
      else $error("loopback levels differ from control");
   chk_id_code: assert property (rd && a == 12'h008 |-> apb_rsp.prdata[7] == apb_rsp.prdata[6] &&
      apb_rsp.prdata[5:0] inside {6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01})
      else $error("source id code illegal");
   chk_sleep_write: assert property ($changed(sleep_en) |-> $past(w4) || $past(w4, 2))
      else $error("sleep changed without mask write");
   chk_ctrl_write: assert property ($changed(modem_ctrl) |-> $past(wc) || $past(wc, 2))
      else $error("control changed without write");
endmodule
bind ums_modem_int ums_modem_int_chk i_chk (.ref_clk, .resetn, .apb_req, .apb_rsp, .modem_pins,
   .sources, .irq, .sleep_en, .loopback, .modem_ctrl);
`default_nettype wire

// [verification/ums_modem_model.sv]
// Modem-side model driving the active-low status pins
`timescale 1ns/1ps
`default_nettype none
module ums_modem_model (
   // Clock
   input wire logic ref_clk,
   // Pins toward the block
   output var ums_pkg::ums_modem_pins_t modem_pins
);
   import ums_pkg::*;
   // Lines rest inactive high until the modem asserts them
   initial modem_pins = 4'hF;
   // New levels land just after an edge, as an unsynchronised line would
   task automatic drive(input logic [3:0] v);
      @(posedge ref_clk);
      modem_pins <= v;
   endtask
endmodule
`default_nettype wire

// [verification/ums_modem_int_bench.sv]
// Self-checking bench for the modem status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module ums_modem_int_bench;
   import ums_pkg::*;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic irq, sleep_en, loopback, e;
   logic [7:0] modem_ctrl;
   logic [31:0] r;
   logic [7:0] ids [4] = '{8'h06, 8'h0C, 8'h04, 8'h02};
   ums_apb_req_t req = '0;
   ums_apb_rsp_t rsp;
   ums_modem_pins_t pins;
   ums_sources_t src = '0;
   int err_count = 0;
   int num_checks = 0;
   // 125 MHz clock
   always #4 ref_clk = ~ref_clk;
   ums_modem_int i_dut (.ref_clk(ref_clk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp), .modem_pins(pins),
      .sources(src), .irq(irq), .sleep_en(sleep_en), .loopback(loopback), .modem_ctrl(modem_ctrl));
   ums_modem_model i_mdm (.ref_clk(ref_clk), .modem_pins(pins));
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x) begin
         err_count++;
         $display("mismatch %s exp %h seen %h", n, x, s);
      end
   endtask
   // One transfer; request held until pready is sampled, then one idle edge
   task automatic ax(input logic w, input logic [11:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      req <= '{1'b1, 1'b0, w, ad, d};
      @(posedge ref_clk);
      req.penable <= 1'b1;
      @(posedge ref_clk);
      while (rsp.pready !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      chk("pready", rsp.pready, 1'b1);
      r = rsp.prdata;
      e = rsp.pslverr;
      req <= '0;
      @(posedge ref_clk);
   endtask
   task automatic rc(input string n, input logic [11:0] ad, input logic [7:0] x);
      ax(1'b0, ad, 32'h0);
      chk(n, r, {24'h0, x});
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #100000;
      err_count++;
      end_of_test();
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      rc("mask", 12'h004, 8'h00);
      rc("id", 12'h008, 8'h01);
      ax(1'b1, 12'h004, 32'hFF);
      rc("mask", 12'h004, 8'h0F);
      chk("sleep", sleep_en, 1'b0);
      ax(1'b1, 12'h010, 32'h10);
      ax(1'b1, 12'h004, 32'h10);
      chk("sleep", sleep_en, 1'b1);
      ax(1'b0, 12'h020, 32'h0);
      chk("slverr", e, 1'b1);
      $display("test mask done");
      // Pin levels and change flags, RI counted on its low-to-high edge only
      i_mdm.drive(4'h5);
      repeat (6) @(posedge ref_clk);
      rc("status", 12'h000, 8'hAA);
      rc("status", 12'h000, 8'hA0);
      i_mdm.drive(4'h0);
      repeat (6) @(posedge ref_clk);
      rc("status", 12'h000, 8'hF1);
      i_mdm.drive(4'hF);
      repeat (6) @(posedge ref_clk);
      rc("status", 12'h000, 8'h0F);
      chk("irq", irq, 1'b0);
      ax(1'b1, 12'h004, 32'h08);
      i_mdm.drive(4'hE);
      repeat (6) @(posedge ref_clk);
      chk("irq", irq, 1'b1);
      rc("id", 12'h008, 8'h00);
      rc("status", 12'h000, 8'h11);
      repeat (2) @(posedge ref_clk);
      chk("irq", irq, 1'b0);
      $display("test modem done");
      // Stacked sources peel off one priority level at a time
      src <= 6'h3C;
      ax(1'b1, 12'h004, 32'h0F);
      for (int i = 0; i < 4; i++) begin
         rc("id", 12'h008, ids[i]);
         if (i < 3) src <= src & ~(6'h20 >> i);
      end
      rc("id", 12'h008, 8'h01);
      ax(1'b1, 12'h004, 32'h0D);
      ax(1'b1, 12'h004, 32'h0F);
      rc("id", 12'h008, 8'h02);
      ax(1'b1, 12'h004, 32'hE0);
      src <= 6'h03;
      @(posedge ref_clk);
      src <= '0;
      rc("id", 12'h008, 8'h10);
      rc("id", 12'h008, 8'h20);
      ax(1'b1, 12'h014, 32'h01);
      rc("id", 12'h008, 8'hC1);
      $display("test priority done");
      // Loopback takes levels from control and ignores the pins
      ax(1'b1, 12'h00C, 32'h1A);
      chk("loop", loopback, 1'b1);
      chk("ctrl", modem_ctrl, 8'h1A);
      i_mdm.drive(4'h0);
      repeat (6) @(posedge ref_clk);
      rc("status", 12'h000, 8'h98);
      rc("status", 12'h000, 8'h90);
      $display("test loopback done");
      end_of_test();
   end
endmodule
`default_nettype wire
